// [lcdid_top.sv]
// Purpose: Instruction decoder, address counter and data RAM access of a character display controller.
// Assumes: Host reaches it over Avalon-MM; display engine reads text and glyphs on the same clock.
// Notes: One wait state per access; instructions and data accesses are ignored while busy.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module lcdid_top #(
  parameter int DATA_CYC = lcdid_pkg::DATA_CYC,
  parameter int HOME_CYC = lcdid_pkg::HOME_CYC,
  parameter int BLINK_HALF_CYC = lcdid_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Display engine
  input wire logic [6:0] disp_pos,
  output logic [7:0] disp_char,
  output logic disp_solid,
  output logic cursor_show,
  input wire logic [5:0] glyph_addr,
  output logic [7:0] glyph_row,
  // Mode status
  output logic two_line,
  output logic font_5x11,
  output logic bus_width_select,
  output logic busy_flag
);
  import lcdid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  logic waitreq_ff, busy_ff, display_on_ff, cursor_on_ff, blink_on_ff, inc_ff, follow_ff;
  logic bus8_ff, two_line_ff, font_ff, glyph_sel_ff, fetch_ff, blink_phase_ff;
  logic [6:0] address_counter_ff, shift_ofs_ff, clr_addr_ff;
  logic [7:0] odr_ff, rd_hold_ff, disp_char_ff, glyph_row_ff;
  logic [31:0] readdata_ff;
  logic disp_solid_ff, cursor_show_ff;
  logic [BUSY_W-1:0] busy_cnt_ff, nxt_busy_cnt;
  logic [BLINK_W-1:0] blink_cnt_ff;
  lcdid_state_t state_ff;
  logic half, mapped, is_instr, is_data, req, commit, take, complete;
  logic inst_go, data_wr_go, data_rd_go;
  logic [3:0] hi_nib;
  logic [7:0] byte_w, rd_byte, dd_rd, dd_disp, cg_rd, cg_glyph;
  logic [6:0] map_addr;
  lcdid_op_t op;

  assign is_instr = avs_address == OFS_INSTR;
  assign is_data = avs_address == OFS_DATA;
  assign mapped = is_instr | is_data;
  assign req = (avs_read | avs_write) & waitreq_ff;
  assign commit = (avs_read | avs_write) & ~waitreq_ff;
  assign take = commit & mapped & (avs_read | avs_byteenable[0]);
  assign complete = bus8_ff | half;
  assign byte_w = bus8_ff ? avs_writedata[7:0] : {hi_nib, avs_writedata[7:4]};
  assign op = lcdid_decode(byte_w);
  assign inst_go = take & avs_write & is_instr & complete & ~busy_ff;
  assign data_wr_go = take & avs_write & is_data & complete & ~busy_ff;
  assign data_rd_go = take & avs_read & is_data & complete & ~busy_ff;
  assign rd_byte = is_instr ? {busy_ff, address_counter_ff} : odr_ff;

  lcdid_nibble u_nibble (
    .clk(clk),
    .rstn(rstn),
    .bus8(bus8_ff),
    .take(take),
    .wr_nib(avs_writedata[7:4]),
    .half(half),
    .hi_nib(hi_nib)
  );

  // Answer one cycle after the request is seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~req;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata_ff <= 32'h0;
      rd_hold_ff <= 8'h00;
    end else if (req && avs_read) begin
      if (!mapped) begin
        readdata_ff <= 32'h0;
      end else if (bus8_ff) begin
        readdata_ff <= {24'h0, rd_byte};
      end else if (!half) begin
        readdata_ff <= {24'h0, rd_byte[7:4], 4'h0};
        rd_hold_ff <= rd_byte;
      end else begin
        readdata_ff <= {24'h0, rd_hold_ff[3:0], 4'h0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy timer; a host that ignores it just has its access dropped
  always_comb begin
    nxt_busy_cnt = (busy_cnt_ff != '0) ? BUSY_W'(busy_cnt_ff - 1'b1) : busy_cnt_ff;
    if (inst_go) begin
      nxt_busy_cnt = (op == OP_CLEAR || op == OP_HOME) ? BUSY_W'(HOME_CYC) : BUSY_W'(INSTR_CYC);
    end else if (data_wr_go || data_rd_go) begin
      nxt_busy_cnt = BUSY_W'(DATA_CYC);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
      busy_ff <= nxt_busy_cnt != '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      display_on_ff <= 1'b0;
      cursor_on_ff <= 1'b0;
      blink_on_ff <= 1'b0;
    end else if (inst_go && op == OP_CTRL) begin
      display_on_ff <= byte_w[BIT_DISP];
      cursor_on_ff <= byte_w[BIT_CURS];
      blink_on_ff <= byte_w[BIT_BLINK];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus8_ff <= RST_BUS8;
      two_line_ff <= 1'b0;
      font_ff <= 1'b0;
    end else if (inst_go && op == OP_FUNC) begin
      bus8_ff <= byte_w[BIT_DL];
      two_line_ff <= byte_w[BIT_N];
      font_ff <= byte_w[BIT_F];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inc_ff <= RST_INC;
      follow_ff <= 1'b0;
    end else if (inst_go && op == OP_ENTRY) begin
      inc_ff <= byte_w[BIT_ID];
      follow_ff <= byte_w[BIT_SH];
    end else if (inst_go && op == OP_CLEAR) begin
      inc_ff <= RST_INC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address counter and RAM target
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      address_counter_ff <= RST_AC;
      glyph_sel_ff <= 1'b0;
    end else if (inst_go) begin
      case (op)
        OP_CLEAR, OP_HOME: begin
          address_counter_ff <= RST_AC;
          glyph_sel_ff <= 1'b0;
        end
        OP_SETCG: begin
          address_counter_ff <= {1'b0, byte_w[5:0]};
          glyph_sel_ff <= 1'b1;
        end
        OP_SETDD: begin
          address_counter_ff <= byte_w[6:0];
          glyph_sel_ff <= 1'b0;
        end
        OP_SHIFT: begin
          // Display shift keeps the counter
          if (!byte_w[BIT_SC]) begin
            address_counter_ff <= lcdid_ac_step(address_counter_ff, byte_w[BIT_RL], two_line_ff,
                                                glyph_sel_ff);
          end
        end
        default: begin
          address_counter_ff <= address_counter_ff;
        end
      endcase
    end else if (data_wr_go || data_rd_go) begin
      address_counter_ff <= lcdid_ac_step(address_counter_ff, inc_ff, two_line_ff,
                                          glyph_sel_ff);
    end
  end

  // One offset for every line, so all lines move together
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_ofs_ff <= 7'h00;
    end else if (inst_go && (op == OP_CLEAR || op == OP_HOME || op == OP_FUNC)) begin
      shift_ofs_ff <= 7'h00;
    end else if ((inst_go && op == OP_SHIFT && byte_w[BIT_SC]) ||
                 (data_wr_go && follow_ff && !glyph_sel_ff)) begin
      if (inst_go ? !byte_w[BIT_RL] : inc_ff) begin
        shift_ofs_ff <= (shift_ofs_ff == (two_line_ff ? LEN_2L : LEN_1L) - 7'h01) ? 7'h00 : 7'(shift_ofs_ff + 7'h01);
      end else begin
        shift_ofs_ff <= (shift_ofs_ff == 7'h00) ? (two_line_ff ? LEN_2L : LEN_1L) - 7'h01 : 7'(shift_ofs_ff - 7'h01);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear sweep writes spaces across the text RAM while busy
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= LID_RUN;
      clr_addr_ff <= 7'h00;
    end else begin
      case (state_ff)
        LID_RUN: begin
          if (inst_go && op == OP_CLEAR) begin
            state_ff <= LID_CLEAR;
            clr_addr_ff <= 7'h00;
          end
        end
        LID_CLEAR: begin
          clr_addr_ff <= 7'(clr_addr_ff + 7'h01);
          if (clr_addr_ff == DD_LAST) begin
            state_ff <= LID_RUN;
          end
        end
        default: begin
          state_ff <= LID_RUN;
        end
      endcase
    end
  end

  lcdid_ram #(.AW(7), .DW(8)) u_text_ram (
    .clk(clk),
    .we((state_ff == LID_CLEAR) || (data_wr_go && !glyph_sel_ff)),
    .waddr((state_ff == LID_CLEAR) ? clr_addr_ff : address_counter_ff),
    .wdata((state_ff == LID_CLEAR) ? CHAR_SPACE : byte_w),
    .raddr0(address_counter_ff),
    .rdata0(dd_rd),
    .raddr1(map_addr),
    .rdata1(dd_disp)
  );

  lcdid_ram #(.AW(6), .DW(8)) u_glyph_ram (
    .clk(clk),
    .we(data_wr_go && glyph_sel_ff),
    .waddr(address_counter_ff[5:0]),
    .wdata(byte_w),
    .raddr0(address_counter_ff[5:0]),
    .rdata0(cg_rd),
    .raddr1(glyph_addr),
    .rdata1(cg_glyph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read latch; a write does not refresh it, so stale data follows a write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fetch_ff <= 1'b0;
      odr_ff <= 8'h00;
    end else begin
      fetch_ff <= (inst_go && (op == OP_SETCG || op == OP_SETDD)) ||
                  (inst_go && op == OP_SHIFT && !byte_w[BIT_SC] && !glyph_sel_ff) ||
                  data_rd_go;
      if (fetch_ff) begin
        odr_ff <= glyph_sel_ff ? cg_rd : dd_rd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display side
  always_comb begin
    if (two_line_ff) begin
      map_addr = {disp_pos[6], 6'(((disp_pos[5:0] + shift_ofs_ff) >= LEN_2L) ?
                 (disp_pos[5:0] + shift_ofs_ff - LEN_2L) : (disp_pos[5:0] + shift_ofs_ff))};
    end else begin
      map_addr = 7'(((disp_pos + shift_ofs_ff) >= LEN_1L) ? (disp_pos + shift_ofs_ff - LEN_1L)
                 : (disp_pos + shift_ofs_ff));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= 1'b0;
    end else if (!blink_on_ff) begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= 1'b0;
    end else if (blink_cnt_ff == BLINK_W'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= ~blink_phase_ff;
    end else begin
      blink_cnt_ff <= BLINK_W'(blink_cnt_ff + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      disp_char_ff <= CHAR_SPACE;
      disp_solid_ff <= 1'b0;
      cursor_show_ff <= 1'b0;
      glyph_row_ff <= 8'h00;
    end else begin
      disp_char_ff <= display_on_ff ? dd_disp : CHAR_SPACE;
      disp_solid_ff <= display_on_ff && blink_on_ff && blink_phase_ff && !glyph_sel_ff &&
                       map_addr == address_counter_ff;
      cursor_show_ff <= display_on_ff && cursor_on_ff && !glyph_sel_ff &&
                        map_addr == address_counter_ff;
      glyph_row_ff <= cg_glyph;
    end
  end

  assign avs_waitrequest = waitreq_ff;
  assign avs_readdata = readdata_ff;
  assign disp_char = disp_char_ff;
  assign disp_solid = disp_solid_ff;
  assign cursor_show = cursor_show_ff;
  assign glyph_row = glyph_row_ff;
  assign two_line = two_line_ff;
  assign font_5x11 = font_ff;
  assign bus_width_select = bus8_ff;
  assign busy_flag = busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_cmd(lcdid_op_t o);
    inst_go && op == o;
  endsequence

  a_ctrl_decode: assert property (s_cmd(OP_CTRL) |=>
    {display_on_ff, cursor_on_ff, blink_on_ff} == $past(byte_w[2:0]))
    else $error("display control bits not taken");
  a_blank_out: assert property (!display_on_ff |=> disp_char_ff == CHAR_SPACE)
    else $error("display off but output not blank");
  a_cursor_hide: assert property (!cursor_on_ff |=> !cursor_show_ff)
    else $error("cursor shown while disabled");
  a_blink_stop: assert property (!blink_on_ff |=> !disp_solid_ff)
    else $error("blink active while disabled");
  a_shift_keep: assert property (s_cmd(OP_SHIFT) ##0 byte_w[BIT_SC] |=> $stable(address_counter_ff))
    else $error("display shift moved address counter");
  a_cursor_step: assert property (s_cmd(OP_SHIFT) ##0 !byte_w[BIT_SC] |=>
    address_counter_ff == lcdid_ac_step($past(address_counter_ff), $past(byte_w[BIT_RL]), two_line_ff, glyph_sel_ff))
    else $error("cursor shift step wrong");
  a_line_wrap: assert property (data_wr_go && two_line_ff && inc_ff && !glyph_sel_ff
    && address_counter_ff == L1_END_2L |=> address_counter_ff == L2_START)
    else $error("no wrap to second line");
  a_func_set: assert property (s_cmd(OP_FUNC) |=> {bus8_ff, two_line_ff, font_ff} == $past(byte_w[4:2]))
    else $error("function set fields not taken");
  a_cg_load: assert property (s_cmd(OP_SETCG) |=> glyph_sel_ff &&
    address_counter_ff == {1'b0, $past(byte_w[5:0])})
    else $error("glyph address set wrong");
  a_busy_read: assert property (req && avs_read && is_instr && bus8_ff |=>
    readdata_ff[7:0] == {$past(busy_ff), $past(address_counter_ff)})
    else $error("busy and address read wrong");
  a_write_step: assert property (data_wr_go |=> address_counter_ff ==
    lcdid_ac_step($past(address_counter_ff), inc_ff, two_line_ff, glyph_sel_ff) ##1 odr_ff == $past(odr_ff, 2))
    else $error("write step or read latch wrong");
  a_busy_span: assert property (s_cmd(OP_CTRL) |=> busy_ff [*8])
    else $error("busy not held after instruction");
endmodule // lcdid_top

// [lcdid_pkg.sv]
// Purpose: Shared constants, types and helpers of the character display instruction decoder.
// Assumes: 100 MHz core clock; display text RAM addresses are 7 bits wide, glyph pattern RAM 6 bits.
// Notes: Execution times are given in ns and turned into cycle counts here.
package lcdid_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_INSTR_NS = 39000;
  localparam int T_DATA_NS = 43000;
  localparam int T_HOME_NS = 1530000;
  localparam int INSTR_CYC = (T_INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_CYC = (T_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOME_CYC = (T_HOME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_CYC = 50000000;
  localparam int BUSY_W = 18;
  localparam int BLINK_W = 26;

  ////////////////////////////////////////////////////////////////////////////
  // Bus map (byte addresses, one 32-bit word each)
  localparam logic [2:0] OFS_INSTR = 3'h0;
  localparam logic [2:0] OFS_DATA = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int BIT_DISP = 2;
  localparam int BIT_CURS = 1;
  localparam int BIT_BLINK = 0;
  localparam int BIT_SC = 3;
  localparam int BIT_RL = 2;
  localparam int BIT_DL = 4;
  localparam int BIT_N = 3;
  localparam int BIT_F = 2;
  localparam int BIT_ID = 1;
  localparam int BIT_SH = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Address map and values after reset
  localparam logic [6:0] L1_END_2L = 7'h27;
  localparam logic [6:0] L2_START = 7'h40;
  localparam logic [6:0] L2_END = 7'h67;
  localparam logic [6:0] END_1L = 7'h4F;
  localparam logic [6:0] LEN_2L = 7'h28;
  localparam logic [6:0] LEN_1L = 7'h50;
  localparam logic [6:0] DD_LAST = 7'h7F;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic RST_BUS8 = 1'b1;
  localparam logic RST_INC = 1'b1;
  localparam logic [6:0] RST_AC = 7'h00;

  typedef enum {LID_RUN, LID_CLEAR} lcdid_state_t;
  typedef enum {OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_CTRL, OP_SHIFT, OP_FUNC, OP_SETCG, OP_SETDD} lcdid_op_t;

  // Highest set bit picks the instruction
  function automatic lcdid_op_t lcdid_decode(input logic [7:0] b);
    lcdid_op_t op;
    op = OP_NONE;
    if (b[7]) op = OP_SETDD;
    else if (b[6]) op = OP_SETCG;
    else if (b[5]) op = OP_FUNC;
    else if (b[4]) op = OP_SHIFT;
    else if (b[3]) op = OP_CTRL;
    else if (b[2]) op = OP_ENTRY;
    else if (b[1]) op = OP_HOME;
    else if (b[0]) op = OP_CLEAR;
    return op;
  endfunction

  // Address counter step with line wrap
  function automatic logic [6:0] lcdid_ac_step(input logic [6:0] ac, input logic up, input logic two_line,
                                               input logic cg);
    logic [6:0] r;
    r = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
    if (cg) r = {1'b0, r[5:0]};
    else if (two_line) begin
      if (up && ac == L1_END_2L) r = L2_START;
      else if (up && ac == L2_END) r = 7'h00;
      else if (!up && ac == 7'h00) r = L2_END;
      else if (!up && ac == L2_START) r = L1_END_2L;
    end else begin
      if (up && ac == END_1L) r = 7'h00;
      else if (!up && ac == 7'h00) r = END_1L;
    end
    return r;
  endfunction

endpackage

// [lcdid_ram.sv]
// Purpose: Small RAM with one write port and two asynchronous read ports.
// Assumes: Single clock; contents are not reset.
// Notes: Used for both the display text RAM and the glyph pattern RAM.
`timescale 1ns/10ps
module lcdid_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read ports
  input wire logic [AW-1:0] raddr0,
  output logic [DW-1:0] rdata0,
  input wire logic [AW-1:0] raddr1,
  output logic [DW-1:0] rdata1
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata0 = mem[raddr0];
  assign rdata1 = mem[raddr1];
endmodule // lcdid_ram

// [lcdid_nibble.sv]
// Purpose: Tracks which half of a byte a 4-bit bus access carries.
// Assumes: Nibbles arrive on the upper data lines, high nibble first.
// Notes: In 8-bit mode every access is a whole byte and the half flag stays low.
`timescale 1ns/10ps
module lcdid_nibble (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic bus8,
  input wire logic take,
  input wire logic [3:0] wr_nib,
  // State
  output logic half,
  output logic [3:0] hi_nib
);
  logic half_ff;
  logic [3:0] hi_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      half_ff <= 1'b0;
    end else if (bus8) begin
      half_ff <= 1'b0;
    end else if (take) begin
      half_ff <= ~half_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_ff <= 4'h0;
    end else if (take && !half_ff) begin
      hi_ff <= wr_nib;
    end
  end

  assign half = half_ff;
  assign hi_nib = hi_ff;
endmodule // lcdid_nibble

// [lcdid_host.sv]
// Purpose: Host model on the Avalon-MM side of the decoder.
// Assumes: One request at a time; signals change only just after a rising edge.
// Notes: Waitrequest and read data are read as they stood at the rising edge, where the slave samples too.
`timescale 1ns/10ps
module lcdid_host (
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [2:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end

  // Holds the request until waitrequest low is taken at a rising edge
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [31:0] q,
                      output logic to);
    int i;
    to = 1'b1;
    q = 32'h0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= 4'hF;
    // Same edge takes the answer and ends the request
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        to = 1'b0;
        q = avs_readdata;
        break;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // lcdid_host

// [lcdid_top_bench.sv]
// Purpose: Self-checking bench of the instruction decoder.
// Assumes: Short data and clear/home busy counts through parameters, instruction count from the package; 8-bit bus except one 4-bit scenario.
// Notes: Every access is preceded by a busy poll, as the host must do.
`timescale 1ns/10ps
module lcdid_top_bench;
  import lcdid_pkg::*;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, two_line, font_5x11, bus_width_select, busy_flag;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [7:0] disp_char, glyph_row;
  logic disp_solid, cursor_show;
  logic [6:0] disp_pos = 7'h27;
  logic [5:0] glyph_addr = 6'h00;
  logic nib_mode = 1'b0;
  int errors = 0;
  int compares = 0;

  always #5 clk = ~clk;

  lcdid_host host_u (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  lcdid_top #(.DATA_CYC(20), .HOME_CYC(200), .BLINK_HALF_CYC(8)) dut_u (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .disp_pos(disp_pos), .disp_char(disp_char), .disp_solid(disp_solid), .cursor_show(cursor_show),
    .glyph_addr(glyph_addr), .glyph_row(glyph_row), .two_line(two_line), .font_5x11(font_5x11),
    .bus_width_select(bus_width_select),
    .busy_flag(busy_flag));

  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [31:0] q);
    logic to;
    host_u.xfer(w, a, d, q, to);
    if (to) begin
      errors++;
      test_done();
    end
  endtask

  // Whole byte in 8-bit mode, two upper-line nibbles high first in 4-bit mode
  task automatic put(input logic [2:0] a, input logic [7:0] b);
    logic [31:0] q;
    if (nib_mode) begin
      acc(1'b1, a, {b[7:4], 4'h0}, q);
      acc(1'b1, a, {b[3:0], 4'h0}, q);
    end else begin
      acc(1'b1, a, b, q);
    end
  endtask

  task automatic get(input logic [2:0] a, output logic [7:0] b);
    logic [31:0] q;
    logic [31:0] q2;
    acc(1'b0, a, 8'h00, q);
    b = q[7:0];
    if (nib_mode) begin
      acc(1'b0, a, 8'h00, q2);
      b = {q[7:4], q2[7:4]};
    end
  endtask

  // Polls until the busy bit reads low; a 4-bit poll is always a full pair
  task automatic idle;
    logic [7:0] b;
    int i;
    for (i = 0; i < 10000; i++) begin
      get(OFS_INSTR, b);
      if (b[7] === 1'b0) break;
    end
    if (i == 10000) begin
      errors++;
      test_done();
    end
  endtask

  task automatic instr(input logic [7:0] b);
    idle();
    put(OFS_INSTR, b);
    // Function set decides how later bytes cross the bus
    if (b[7:5] == 3'h1) nib_mode = !b[4];
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_lines;
    logic [31:0] q;
    instr(8'h38);
    `CHK("two_line", 1'b1, two_line)
    `CHK("font", 1'b0, font_5x11)
    `CHK("bus8", 1'b1, bus_width_select)
    instr(8'hA7);
    acc(1'b1, OFS_DATA, 8'h41, q);
    acc(1'b0, OFS_INSTR, 8'h00, q);
    `CHK("busy", 1'b1, q[7])
    idle();
    acc(1'b0, OFS_INSTR, 8'h00, q);
    `CHK("ac_wrap", 7'h40, q[6:0])
  endtask

  // Address set first, so the first read is valid
  task automatic t_read;
    logic [31:0] q;
    instr(8'hA7);
    acc(1'b0, OFS_DATA, 8'h00, q);
    `CHK("rd_data", 8'h41, q[7:0])
    idle();
    acc(1'b0, OFS_INSTR, 8'h00, q);
    `CHK("ac_rd", 7'h40, q[6:0])
    instr(8'h0C);
    `CHK("disp_on", 8'h41, disp_char)
  endtask

  task automatic t_shift;
    logic [31:0] q;
    instr(8'h10);
    acc(1'b0, OFS_INSTR, 8'h00, q);
    `CHK("ac_left", 7'h27, q[6:0])
    instr(8'h18);
    acc(1'b0, OFS_INSTR, 8'h00, q);
    `CHK("ac_dshift", 7'h27, q[6:0])
    instr(8'h08);
    `CHK("disp_off", 8'h20, disp_char)
    acc(1'b0, 3'h2, 8'h00, q);
    `CHK("unmapped", 32'h0, q)
  endtask

  // Clear, cursor and blink, decrement entry, stale latch, glyph RAM
  task automatic t_modes;
    logic [7:0] b;
    int n;
    instr(8'h01);
    instr(8'h0F);
    disp_pos <= 7'h00;
    repeat (2) @(posedge clk);
    `CHK("clr_char", 8'h20, disp_char)
    `CHK("cursor_at", 1'b1, cursor_show)
    n = 0;
    repeat (16) begin
      @(posedge clk);
      if (disp_solid === 1'b1) n++;
    end
    `CHK("blink_on", 8, n)
    disp_pos <= 7'h01;
    repeat (2) @(posedge clk);
    `CHK("cursor_off", 1'b0, cursor_show)
    instr(8'h04);
    instr(8'h85);
    put(OFS_DATA, 8'h5A);
    instr(8'h85);
    put(OFS_DATA, 8'h66);
    idle();
    get(OFS_INSTR, b);
    `CHK("ac_dec", 7'h04, b[6:0])
    get(OFS_DATA, b);
    `CHK("stale_rd", 8'h5A, b)
    instr(8'h43);
    put(OFS_DATA, 8'hA5);
    glyph_addr <= 6'h03;
    instr(8'h43);
    `CHK("glyph_row", 8'hA5, glyph_row)
    get(OFS_DATA, b);
    `CHK("glyph_rd", 8'hA5, b)
  endtask

  // 4-bit bus round trip, then back to 8-bit
  task automatic t_nib;
    logic [7:0] b;
    instr(8'h28);
    `CHK("bus4", 1'b0, bus_width_select)
    instr(8'h06);
    instr(8'h80); // Text RAM again before any display shift
    put(OFS_DATA, 8'h4B);
    idle();
    get(OFS_INSTR, b);
    `CHK("ac_nib", 7'h01, b[6:0])
    instr(8'h80);
    get(OFS_DATA, b);
    `CHK("rd_nib", 8'h4B, b)
    instr(8'h38);
    `CHK("bus8_back", 1'b1, bus_width_select)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_lines();
    t_read();
    t_shift();
    t_modes();
    t_nib();
    test_done();
  end
endmodule // lcdid_top_bench
